// [rtl/serial_config_prom_readout.sv]
// serial configuration read-out: bit store, prefetch buffer, shifter and apb slave
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module serial_config_prom_readout
  import prom_readout_pkg::*;
#(
  parameter int POR_HOLD_CYCLES = POR_HOLD_CYCLES_DEF,
  parameter int PD_TRIP_CYCLES  = PD_TRIP_CYCLES_DEF,
  parameter int REV_WORDS       = 256
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cfg_clk,
  input  wire logic              chip_enable_n,
  input  wire logic              oe_reset_i,
  output logic                   oe_reset_o,
  output logic                   oe_reset_oe,
  input  wire logic              config_pulse_n,
  input  wire logic              revision_select_0,
  input  wire logic              revision_select_1,
  input  wire logic              external_select_enable_n,
  input  wire logic              core_supply_low,
  output logic                   serial_data_out,
  output logic                   serial_data_out_oe,
  output logic                   clock_out,
  output logic                   clock_out_oe
);

  localparam int CNT_W     = 21;
  localparam int BA_W      = 24;
  localparam int RW_AW     = $clog2(REV_WORDS);
  localparam int MEM_AW    = REV_AW + RW_AW;
  localparam int MEM_DEPTH = REV_COUNT * REV_WORDS;
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] PD_LAST  = CNT_W'(PD_TRIP_CYCLES - 1);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (POR_HOLD_CYCLES < 1 || POR_HOLD_CYCLES > 2**CNT_W) begin : g_bad_por
    $error("por hold count out of range");
  end
  if (PD_TRIP_CYCLES < 1 || PD_TRIP_CYCLES > 2**CNT_W) begin : g_bad_pd
    $error("power-down trip count out of range");
  end
  if (REV_WORDS < 2 || (1 << RW_AW) != REV_WORDS) begin : g_bad_words
    $error("revision size must be a power of two");
  end

  // ------------------------------------------------------------------
  // address decode shared by read and write paths
  // ------------------------------------------------------------------
  function automatic logic is_mapped(input logic [APB_AW-1:0] a);
    is_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_MEM_ADDR) ||
                (a == REG_MEM_DATA) || (a == REG_BIT_ADDR);
  endfunction

  logic [SYNC_W-1:0]  sync1_q, sync2_q;
  logic               clk_prev_q;
  state_e             state_q, state_d;
  logic [CNT_W-1:0]   por_cnt_q, por_cnt_d, pd_cnt_q, pd_cnt_d;
  logic [REV_AW-1:0]  rev_q, rev_d, dflt_rev_q, dflt_rev_d, sel_rev;
  logic [RW_AW-1:0]   word_ptr_q, word_ptr_d;
  logic [BA_W-1:0]    bit_addr_q, bit_addr_d;
  logic [WORD_W-1:0]  buf_q [2];
  logic [WORD_W-1:0]  buf_d [2];
  logic [1:0]         count_q, count_d;
  logic               pend_q, pend_d;
  logic [WORD_W-1:0]  sh_q, sh_d;
  logic [5:0]         sh_bits_q, sh_bits_d;
  logic               sdo_q, sdo_d, cko_q, cko_d;
  logic               underrun_q, underrun_d, underrun_set;
  logic [MEM_AW-1:0]  mem_addr_q, mem_addr_d;
  logic [31:0]        prdata_q, prdata_d;
  logic [WORD_W-1:0]  mem_rdata;
  logic               cclk_s, ce_n_s, oe_s, pulse_s, ext_n_s, low_s;
  logic               cclk_rise, en, live, issue, pop, push, buf_ready;
  logic               access, wr_ok, mem_we, w1c_underrun;
  logic [2:0]         occ;

  // ------------------------------------------------------------------
  // pin synchronisers: only the second stage is ever looked at
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q    <= SYNC_RST;
      sync2_q    <= SYNC_RST;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {core_supply_low, external_select_enable_n, revision_select_1,
                     revision_select_0, config_pulse_n, oe_reset_i, chip_enable_n, cfg_clk};
      sync2_q    <= sync1_q;
      clk_prev_q <= sync2_q[SY_CCLK];
    end
  end

  // decoded pin levels and enables
  assign cclk_s    = sync2_q[SY_CCLK];
  assign ce_n_s    = sync2_q[SY_CE_N];
  assign oe_s      = sync2_q[SY_OE];
  assign pulse_s   = sync2_q[SY_PULSE];
  assign ext_n_s   = sync2_q[SY_EXT_N];
  assign low_s     = sync2_q[SY_LOW];
  assign cclk_rise = cclk_s & ~clk_prev_q;                  // edge found on the pclk side
  assign en        = ~ce_n_s & oe_s & (state_q != ST_POR);
  assign live      = en & (state_q == ST_RUN);
  // straps pick the revision unless external select is off; pins low give zero
  assign sel_rev   = ext_n_s ? dflt_rev_q : {sync2_q[SY_REV1], sync2_q[SY_REV0]};

  // ------------------------------------------------------------------
  // prefetch: at most two words between store and shifter
  // ------------------------------------------------------------------
  assign occ       = {1'b0, count_q} + {2'b00, pend_q};
  assign buf_ready = (count_q != 2'd2);
  assign issue     = live & (occ < 3'd2);      // counting the word in flight keeps push legal
  assign push      = pend_q & buf_ready;

  bitstream_mem #(
    .WIDTH (WORD_W),
    .DEPTH (MEM_DEPTH)
  ) u_mem (
    .clk     (pclk),
    .we      (mem_we),
    .waddr   (mem_addr_q),
    .wdata   (pwdata),
    .re      (issue),
    .raddr   ({rev_q, word_ptr_q}),
    .rdata_q (mem_rdata)
  );

  // ------------------------------------------------------------------
  // sequencer, address counter, buffer and shifter: next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d      = state_q;
    por_cnt_d    = por_cnt_q;
    pd_cnt_d     = pd_cnt_q;
    rev_d        = rev_q;
    word_ptr_d   = word_ptr_q;
    bit_addr_d   = bit_addr_q;
    buf_d        = buf_q;
    count_d      = count_q;
    pend_d       = 1'b0;
    sh_d         = sh_q;
    sh_bits_d    = sh_bits_q;
    sdo_d        = sdo_q;
    cko_d        = 1'b0;
    pop          = 1'b0;
    underrun_set = 1'b0;
    case (state_q)
      ST_POR: begin
        if (low_s) begin
          por_cnt_d = '0;
        end else if (por_cnt_q == POR_LAST) begin   // release after the hold time
          state_d   = ST_IDLE;
          por_cnt_d = '0;
        end else begin
          por_cnt_d = por_cnt_q + 1'b1;
        end
      end
      ST_IDLE: begin
        if (en && pulse_s) begin
          state_d = ST_RUN;
          rev_d   = sel_rev;                         // selected revision (straps or ctrl default) caught at start
        end
      end
      ST_RUN: begin
        if (!en) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
    // a brief supply dip is ignored; only a long one restarts the device
    if (low_s) begin
      if (pd_cnt_q == PD_LAST) begin
        state_d   = ST_POR;
        por_cnt_d = '0;
      end else begin
        pd_cnt_d = pd_cnt_q + 1'b1;
      end
    end else begin
      pd_cnt_d = '0;
    end
    if (!live) begin
      // disabled: address back to the start, pipeline flushed
      word_ptr_d = '0;
      bit_addr_d = '0;
      count_d    = 2'd0;
      sh_bits_d  = 6'd0;
      sdo_d      = 1'b0;
    end else begin
      cko_d  = cclk_s;
      pend_d = issue;
      if (issue) begin
        word_ptr_d = word_ptr_q + 1'b1;              // stored order, wraps at revision end
      end
      if (pulse_s && cclk_rise) begin                // only with config pulse high
        bit_addr_d = bit_addr_q + 1'b1;              // one position per edge
        if (sh_bits_q > 6'd1) begin
          sh_d      = sh_q << 1;
          sh_bits_d = sh_bits_q - 1'b1;
          sdo_d     = sh_q[WORD_W-2];                // next bit after the edge
        end else if (count_q != 2'd0) begin
          pop       = 1'b1;
          sh_d      = buf_q[0];
          sh_bits_d = WORD_BITS;
          sdo_d     = buf_q[0][WORD_W-1];
        end else begin
          sh_bits_d    = 6'd0;
          underrun_set = 1'b1;                       // controller outran the store
        end
      end else if (sh_bits_q == 6'd0 && count_q != 2'd0) begin
        pop       = 1'b1;                            // first bit shown before any edge
        sh_d      = buf_q[0];
        sh_bits_d = WORD_BITS;
        sdo_d     = buf_q[0][WORD_W-1];
      end
      // two-entry fifo bookkeeping
      if (pop && push) begin
        if (count_q == 2'd1) begin
          buf_d[0] = mem_rdata;
        end else begin
          buf_d[0] = buf_q[1];
          buf_d[1] = mem_rdata;
        end
      end else if (pop) begin
        buf_d[0] = buf_q[1];
        count_d  = count_q - 1'b1;
      end else if (push) begin
        buf_d[count_q[0]] = mem_rdata;
        count_d           = count_q + 1'b1;
      end
    end
    // set wins over a software clear in the same cycle
    underrun_d = underrun_set | (underrun_q & ~w1c_underrun);
  end

  // sequencer and datapath registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_POR;
      por_cnt_q  <= '0;
      pd_cnt_q   <= '0;
      rev_q      <= REV_DEFAULT;
      word_ptr_q <= '0;
      bit_addr_q <= '0;
      buf_q[0]   <= '0;
      buf_q[1]   <= '0;
      count_q    <= 2'd0;
      pend_q     <= 1'b0;
      sh_q       <= '0;
      sh_bits_q  <= 6'd0;
      sdo_q      <= 1'b0;
      cko_q      <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      por_cnt_q  <= por_cnt_d;
      pd_cnt_q   <= pd_cnt_d;
      rev_q      <= rev_d;
      word_ptr_q <= word_ptr_d;
      bit_addr_q <= bit_addr_d;
      buf_q      <= buf_d;
      count_q    <= count_d;
      pend_q     <= pend_d;
      sh_q       <= sh_d;
      sh_bits_q  <= sh_bits_d;
      sdo_q      <= sdo_d;
      cko_q      <= cko_d;
      underrun_q <= underrun_d;
    end
  end

  // ------------------------------------------------------------------
  // pins: open-drain reset hold and tri-state enables
  // ------------------------------------------------------------------
  assign oe_reset_o         = 1'b0;
  assign oe_reset_oe        = (state_q == ST_POR);  // pulled low until released
  assign serial_data_out    = sdo_q;                 // the only data line
  assign clock_out          = cko_q;
  assign serial_data_out_oe = en;                    // floats unless both enables hold and the power-on hold is over
  assign clock_out_oe       = en;

  // ------------------------------------------------------------------
  // apb slave: zero wait states, read data captured in the setup cycle
  // ------------------------------------------------------------------
  assign access       = psel & penable;
  assign wr_ok        = access & pwrite & is_mapped(paddr) & (pstrb == FULL_STRB);
  assign mem_we       = wr_ok & (paddr == REG_MEM_DATA);
  assign w1c_underrun = wr_ok & (paddr == REG_STATUS) & pwdata[STAT_UNDERRUN];
  assign pready       = 1'b1;
  assign pslverr      = access & (~is_mapped(paddr) | (pwrite & (pstrb != FULL_STRB)));
  assign prdata       = prdata_q;

  // register file next values
  always_comb begin
    dflt_rev_d = dflt_rev_q;
    mem_addr_d = mem_addr_q;
    prdata_d   = prdata_q;
    if (wr_ok && paddr == REG_CTRL) begin
      dflt_rev_d = pwdata[CTRL_REV_LSB +: REV_AW];
    end
    if (wr_ok && paddr == REG_MEM_ADDR) begin
      mem_addr_d = pwdata[MEM_AW-1:0];
    end else if (mem_we) begin
      mem_addr_d = mem_addr_q + 1'b1;                // burst loading without re-addressing
    end
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        REG_CTRL: begin
          prdata_d[CTRL_REV_LSB +: REV_AW] = dflt_rev_q;
        end
        REG_STATUS: begin
          prdata_d[STAT_ENABLED_BIT]         = en;
          prdata_d[STAT_POR_DONE]            = (state_q != ST_POR);
          prdata_d[STAT_UNDERRUN]            = underrun_q;
          prdata_d[STAT_REV_LSB +: REV_AW]   = rev_q;
        end
        REG_MEM_ADDR: begin
          prdata_d[MEM_AW-1:0] = mem_addr_q;
        end
        REG_BIT_ADDR: begin
          prdata_d[BA_W-1:0] = bit_addr_q;
        end
        default: begin
          prdata_d = 32'h0000_0000;                  // data port and holes read zero
        end
      endcase
    end
  end

  // register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dflt_rev_q <= REV_DEFAULT;
      mem_addr_q <= '0;
      prdata_q   <= 32'h0000_0000;
    end else begin
      dflt_rev_q <= dflt_rev_d;
      mem_addr_q <= mem_addr_d;
      prdata_q   <= prdata_d;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_shift_edge;
    live && pulse_s && cclk_rise && (sh_bits_q > 6'd1);
  endsequence

  sequence s_start_run;
    (state_q == ST_IDLE) && en && pulse_s;
  endsequence

  chk_oe_low_float: assert property (
    !oe_s |-> !serial_data_out_oe && !clock_out_oe ##1 bit_addr_q == '0)
    else $error("outputs driven or address kept while oe/reset low");
  chk_ce_high_float: assert property (
    ce_n_s |-> !serial_data_out_oe && !clock_out_oe ##1 (bit_addr_q == '0 && !sdo_q))
    else $error("outputs driven or address kept while chip enable high");
  chk_drive_enabled: assert property (
    (!ce_n_s && oe_s && state_q != ST_POR) |-> serial_data_out_oe && clock_out_oe)
    else $error("outputs not driven while enabled");
  chk_hold_without_pulse: assert property (
    (live && !pulse_s && state_d == ST_RUN) |=> $stable(bit_addr_q))
    else $error("bit address moved with config pulse low");
  chk_next_bit: assert property (
    s_shift_edge |=> serial_data_out == $past(sh_q[WORD_W-2]) && sh_bits_q == $past(sh_bits_q) - 1)
    else $error("next bit not presented after clock edge");
  chk_addr_step: assert property (
    (live && pulse_s && cclk_rise) |=> bit_addr_q == $past(bit_addr_q) + 1'b1)
    else $error("bit address did not advance by one");
  chk_por_release: assert property (
    (state_q == ST_POR && por_cnt_q == POR_LAST && !low_s && pd_cnt_q != PD_LAST)
    |=> state_q == ST_IDLE && !oe_reset_oe)
    else $error("oe/reset not released at the end of the hold time");
  chk_por_drive: assert property (
    (state_q == ST_POR) |-> oe_reset_oe && !oe_reset_o && !serial_data_out_oe)
    else $error("oe/reset not held low during power-on hold");
  chk_pd_trip: assert property (
    (low_s && pd_cnt_q == PD_LAST) |=> state_q == ST_POR)
    else $error("long supply drop did not reset the device");
  chk_pd_short: assert property (
    (state_q != ST_POR && (!low_s || pd_cnt_q != PD_LAST)) |=> state_q != ST_POR)
    else $error("reset without a long supply drop");
  chk_rev_pick: assert property (
    s_start_run |=> rev_q == $past(sel_rev) && state_q == ST_RUN)
    else $error("revision not taken from the select inputs");
  chk_rev_zero: assert property (
    (s_start_run and (!ext_n_s && !sync2_q[SY_REV0] && !sync2_q[SY_REV1]))
    |=> rev_q == REV_DEFAULT)
    else $error("grounded straps did not pick revision zero");

endmodule
`default_nettype wire

// [shared/prom_readout_pkg.sv]
// constants, register map and state encoding for the serial config read-out block
package prom_readout_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses on the APB slave)
  // ------------------------------------------------------------------
  localparam int          APB_AW       = 12;
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_MEM_ADDR = 12'h008;
  localparam logic [11:0] REG_MEM_DATA = 12'h00c;
  localparam logic [11:0] REG_BIT_ADDR = 12'h010;
  localparam logic [3:0]  FULL_STRB    = 4'hf;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int         CTRL_REV_LSB     = 0;
  localparam int         STAT_ENABLED_BIT = 0;
  localparam int         STAT_POR_DONE    = 1;
  localparam int         STAT_UNDERRUN    = 2;
  localparam int         STAT_REV_LSB     = 4;
  localparam logic [1:0] REV_DEFAULT      = 2'h0;
  localparam int         REV_AW           = 2;
  localparam int         REV_COUNT        = 4;
  localparam int         WORD_W           = 32;
  localparam logic [5:0] WORD_BITS        = 6'h20;

  // ------------------------------------------------------------------
  // synchroniser lanes for the pins
  // ------------------------------------------------------------------
  localparam int         SYNC_W   = 8;
  localparam int         SY_CCLK  = 0;
  localparam int         SY_CE_N  = 1;
  localparam int         SY_OE    = 2;
  localparam int         SY_PULSE = 3;
  localparam int         SY_REV0  = 4;
  localparam int         SY_REV1  = 5;
  localparam int         SY_EXT_N = 6;
  localparam int         SY_LOW   = 7;
  localparam logic [7:0] SYNC_RST = 8'h0e;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam real CLK_PERIOD_NS      = 8.0;
  localparam real POR_RELEASE_MIN_MS = 0.5;
  localparam real PD_RESET_MIN_MS    = 10.0;
  localparam int  POR_HOLD_CYCLES_DEF = int'($ceil(POR_RELEASE_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  PD_TRIP_CYCLES_DEF  = int'($ceil(PD_RESET_MIN_MS * 1.0e6 / CLK_PERIOD_NS));

  // ------------------------------------------------------------------
  // sequencer states, gray along por -> idle -> run
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b11
  } state_e;

endpackage

// [rtl/bitstream_mem.sv]
// simple dual-port bitstream store with registered read data
`timescale 1ns/1ps
`default_nettype none
module bitstream_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 1024
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic                     re,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // a one-word store would leave the address port without bits
  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_size
    $error("memory size out of range");
  end

  // ------------------------------------------------------------------
  // storage: no reset, contents are loaded by software
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    if (re) begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule
`default_nettype wire

// [bench/cfg_ctrl_model.sv]
// configuration controller model: drives the link clock one pulse at a time
`timescale 1ns/1ps
`default_nettype none
module cfg_ctrl_model (
  output logic cfg_clk
);
  // clock stands low between pulses; phase kept off the pclk grid
  initial cfg_clk = 1'b0;
  task automatic pulse();
    #3 cfg_clk = 1'b1;
    #40 cfg_clk = 1'b0;
    #34; // ends off the pclk edge, so the caller's next edge is certain
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the serial configuration read-out block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import prom_readout_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, pull_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic cfg_clk, ce_n, oe_w, oe_o, oe_oe, pulse_n, rs0, rs1, ext_n, low;
  logic sdo, sdo_oe, cko, cko_oe;
  int   miscompares, total_checks;
  // open-drain wire: either party pulls it low
  assign oe_w = (oe_oe ? oe_o : 1'b1) & ~pull_q;
  cfg_ctrl_model u_ctl (.cfg_clk(cfg_clk));
  serial_config_prom_readout #(.POR_HOLD_CYCLES(20), .PD_TRIP_CYCLES(30), .REV_WORDS(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_clk(cfg_clk), .chip_enable_n(ce_n), .oe_reset_i(oe_w),
    .oe_reset_o(oe_o), .oe_reset_oe(oe_oe), .config_pulse_n(pulse_n), .revision_select_0(rs0),
    .revision_select_1(rs1), .external_select_enable_n(ext_n), .core_supply_low(low),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .clock_out(cko),
    .clock_out_oe(cko_oe));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] word(input int i);
    return 32'ha5c3_0f00 ^ (i * 32'h0111_1011);
  endfunction
  // apb master: hold the request until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // read a serial run of n bits starting at stored word w0
  task automatic stream(input int w0, input int n);
    logic [31:0] wv;
    for (int k = 0; k < n; k++) begin
      wv = word(w0 + k / 32);
      chk({31'h0, wv[31 - k % 32]}, {31'h0, sdo}, "sdo");
      u_ctl.pulse();
      @(posedge pclk);
    end
  endtask
  // hang guard, ceiling well above the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end
  initial begin
    // chip stays deselected until the store is loaded
    {presetn, psel, penable, pwrite, pull_q, ce_n, pulse_n, rs0, rs1, ext_n, low} = 11'b000_0011_0000;
    paddr = 12'h000; pwdata = 32'h0000_0000; total_checks = 0; miscompares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(1, oe_oe, "por_hold");
    chk(0, oe_w, "por_wire");
    repeat (25) @(posedge pclk);
    chk(0, oe_oe, "por_release");
    xfer(1, REG_MEM_ADDR, 0);
    for (int i = 0; i < 8; i++) xfer(1, REG_MEM_DATA, word(i));
    $display("test por_and_load done");
    ce_n <= 1'b0; // straps low select revision zero; read only after release
    pulse_n <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(3, {sdo_oe, cko_oe}, "oe_on");
    stream(0, 40);
    xfer(0, REG_BIT_ADDR, 0);
    chk(40, rdat, "bit_addr");
    pulse_n <= 1'b0; // paused edges must not count
    repeat (4) @(posedge pclk);
    // clock-out still echoes the link clock while paused
    fork
      u_ctl.pulse();
      begin
        repeat (4) @(posedge pclk);
        chk(1, cko, "clock_out");
      end
    join
    @(posedge pclk);
    xfer(0, REG_BIT_ADDR, 0);
    chk(40, rdat, "bit_addr_pause");
    pulse_n <= 1'b1;
    ce_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(0, {sdo_oe, cko_oe}, "oe_ce_off");
    xfer(0, REG_BIT_ADDR, 0);
    chk(0, rdat, "bit_addr_ce");
    $display("test rev0_stream done");
    rs0 <= 1'b1; ce_n <= 1'b0;
    repeat (12) @(posedge pclk);
    xfer(0, REG_STATUS, 0);
    chk(1, rdat[5:4], "active_rev");
    stream(4, 8);
    pull_q <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(0, {sdo_oe, cko_oe}, "oe_reset_off");
    xfer(0, REG_BIT_ADDR, 0);
    chk(0, rdat, "bit_addr_oe");
    pull_q <= 1'b0;
    xfer(0, 12'h100, 0);
    chk(1, rerr, "unmapped_err");
    $display("test rev1_and_float done");
    low <= 1'b1; // short dip must not reset
    repeat (10) @(posedge pclk);
    chk(0, oe_oe, "pd_short");
    repeat (30) @(posedge pclk);
    chk(1, oe_oe, "pd_trip");
    low <= 1'b0;
    $display("test power_down done");
    test_done();
  end
endmodule
`default_nettype wire
